// ===== bench/serial_register_port_tb.sv
/*
 * Testbench: software frames through the master's Wishbone registers,
 * compared against the device's register image and read data.
 * Assumes the master and device sit on one 25 MHz clock.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h seen %h", n, e, g); \
    end end
module serial_register_port_tb;
    import srp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic abort_q = 1'b0;
    logic host_rst;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [2:0] margin = 3'h0;
    logic [31:0] sig = 32'h0;
    logic [255:0] reg_image;
    logic soft_reset;
    logic [31:0] rdat;
    int miscompares = 0;
    int checked = 0;

    // Master reset doubles as a mid-frame abort
    assign host_rst = rst | abort_q;
    always #20 clock = ~clock;
    srp_link_if link();
    srp_device u_srp_device(.CLOCK(clock), .RST(rst), .LINK(link),
        .MARGIN_STATUS(margin), .SELFTEST_SIG(sig), .REG_IMAGE(reg_image),
        .SOFT_RESET(soft_reset));
    srp_host u_srp_host(.CLOCK(clock), .RST(host_rst), .LINK(link),
        .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
        .WB_ADR_I(wb_adr), .WB_SEL_I(4'hf), .WB_DAT_I(wb_dat),
        .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack));
    srp_link_monitor u_srp_link_monitor(.CLOCK(clock), .RST(host_rst),
        .spi_clk(link.spi_clk), .chip_select_n(link.chip_select_n),
        .serial_out_pin_o(link.serial_out_pin_o),
        .serial_out_pin_oe(link.serial_out_pin_oe),
        .dev_dio_oe(link.dev_dio_oe), .REG_IMAGE(reg_image));

    // --------
    // Tasks
    // --------
    function automatic logic [7:0] img(input logic [4:0] a);
        return reg_image[8 * a +: 8];
    endfunction
    task automatic wb_cycle(input logic we, input logic [3:0] a,
                            input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge clock); while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic frame(input logic [9:0] ctrl, input logic [31:0] tx);
        wb_cycle(1'b1, HOST_TXDATA_ADR, tx);
        wb_cycle(1'b1, HOST_CTRL_ADR, {22'h0, ctrl});
        do wb_cycle(1'b0, HOST_STATUS_ADR, 32'h0); while (rdat[0] !== 1'b0);
        wb_cycle(1'b0, HOST_RXDATA_ADR, 32'h0);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // --------
    // Tests
    // --------
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK("cfg_rst", 8'h00, img(5'h00))
        frame(10'h08b, 32'h0);
        `CHK("rd_0b", 8'hf9, rdat[7:0])
        frame(10'h024, 32'h3c5a);
        `CHK("wr_04_03", 16'h5a3c, {img(5'h04), img(5'h03)})
        frame(10'h0a4, 32'h0);
        `CHK("rd_04_03", 16'h3c5a, rdat[15:0])
        frame(10'h06e, 32'hffffffff);
        `CHK("wr4", 32'hc3ff03ff, reg_image[8 * 11 +: 32])
        `CHK("wr4_edge", 8'h00, img(5'h0a))
        margin <= 3'h5;
        sig <= 32'h44332211;
        frame(10'h0c6, 32'h0);
        `CHK("rd3", 24'h5a0005, rdat[23:0])
        frame(10'h0fe, 32'h0);
        `CHK("rd_sig", 32'h11223344, rdat)
        wb_cycle(1'b1, HOST_TXDATA_ADR, 32'h1f);
        wb_cycle(1'b1, HOST_CTRL_ADR, 32'h005);
        repeat (200) @(posedge clock);
        // Held two cycles so the checker's disable spans the cut frame
        abort_q <= 1'b1;
        repeat (2) @(posedge clock);
        abort_q <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK("abort", 8'h00, img(5'h05))
        frame(10'h005, 32'h1f);
        `CHK("restart", 8'h1f, img(5'h05))
        frame(10'h000, 32'hc0);
        `CHK("cfg", 8'hc0, img(5'h00))
        frame(10'h3bf, 32'h0);
        `CHK("wrap", {8'hc0, IDENTITY_DEFAULT}, rdat[15:0])
        frame(10'h323, 32'h2211);
        `CHK("lsb_wr", 16'h2211, {img(5'h04), img(5'h03)})
        frame(10'h300, 32'he0);
        `CHK("sreset", 1'b1, soft_reset)
        `CHK("sreset_reg", 8'h00, img(5'h04))
        frame(10'h300, 32'hc0);
        `CHK("sreset_off", 1'b0, soft_reset)
        `CHK("idle_pin", 1'b1, link.dio)
        finish_test();
    end

    // Whole run is about 5k cycles
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        finish_test();
    end
endmodule

// ===== bench/srp_link_monitor.sv
/*
 * Link checker: watches the pins joining the serial master and the
 * register port device. Assumes RST covers both ends' resets and that
 * REG_IMAGE byte 0 is the device's serial port configuration.
 */
`timescale 1ns/10ps
module srp_link_monitor (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic spi_clk,
    input wire logic chip_select_n,
    input wire logic serial_out_pin_o,
    input wire logic serial_out_pin_oe,
    input wire logic dev_dio_oe,
    input wire logic [255:0] REG_IMAGE
);
    // --------
    // Rising link clock edges seen in the current frame
    // --------
    logic [5:0] rises_q;
    logic sck_q;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rises_q <= 6'h00;
            sck_q <= 1'b0;
        end else begin
            sck_q <= spi_clk;
            if (chip_select_n) begin
                rises_q <= 6'h00;
            end else if (spi_clk && !sck_q) begin
                rises_q <= rises_q + 6'h01;
            end
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_high;
        spi_clk [*8];
    endsequence

    // --------
    // Checks
    // --------
    a_cs_floats: assert property (
        chip_select_n |-> !dev_dio_oe && !serial_out_pin_oe)
        else $error("data pin driven while deselected");
    a_three_wire_quiet: assert property (
        REG_IMAGE[7] |-> !serial_out_pin_oe)
        else $error("output pin driven in three-wire mode");
    a_dio_mode: assert property (
        dev_dio_oe |-> REG_IMAGE[7])
        else $error("shared pin driven in four-wire mode");
    a_out_stable: assert property (
        spi_clk && $past(spi_clk) && serial_out_pin_oe
        && $past(serial_out_pin_oe) |-> $stable(serial_out_pin_o))
        else $error("read bit changed while link clock high");
    a_sck_idle: assert property (
        chip_select_n |-> !spi_clk)
        else $error("link clock toggles outside a frame");
    a_cs_gap: assert property (
        $rose(chip_select_n) |-> chip_select_n [*2])
        else $error("select high for under two cycles");
    a_half_period: assert property (
        $rose(spi_clk) |-> s_high ##1 !spi_clk)
        else $error("link clock high phase not eight cycles");
    a_read_start: assert property (
        $rose(dev_dio_oe) || $rose(serial_out_pin_oe) |-> rises_q == 6'h08)
        else $error("read drive starts off the instruction end");
    a_frame_whole: assert property (
        $rose(chip_select_n) |-> rises_q[2:0] == 3'h0 && rises_q != 6'h00)
        else $error("frame ends on a partial byte");
endmodule

// ===== src/srp_device.sv
/*
 * Serial register port, device end: instruction decoder, address generator
 * and the 32-entry register file behind it.
 * Assumes the link pins arrive from outside the CLOCK domain and that the
 * link clock is much slower than CLOCK (at least 8 CLOCK periods high/low).
 */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module srp_device (
    input wire logic CLOCK,
    input wire logic RST,
    srp_link_if.dev LINK,
    input wire logic [2:0] MARGIN_STATUS,
    input wire logic [31:0] SELFTEST_SIG,
    output logic [255:0] REG_IMAGE,
    output logic SOFT_RESET
);
    import srp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sck_sync;
        logic [1:0] cs_sync;
        logic [1:0] din_sync;
        logic in_instr;
        logic rd;
        logic done;
        logic drive;
        logic dout;
        logic [2:0] bitcnt;
        logic [1:0] left;
        logic [4:0] addr;
        logic [7:0] shreg;
        logic [7:0] txbuf;
        logic [31:0][7:0] regs;
    } srp_dev_t;

    srp_dev_t q;
    srp_dev_t d;
    logic sck_rise;
    logic sck_fall;
    logic cs_high;
    logic din;
    logic low_first;
    logic three_wire;
    logic [7:0] nxt_byte;
    logic [4:0] nxt_addr;
    logic [31:0][7:0] rst_regs;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Status and signature come from live inputs, identity from a constant, not from the file
    function automatic logic [7:0] read_reg(input logic [4:0] a,
                                            input logic [31:0][7:0] r);
        unique case (a)
            INPUT_MARGIN_STATUS: return {5'h00, MARGIN_STATUS};
            SELFTEST_SIG1_LOW: return SELFTEST_SIG[7:0];
            SELFTEST_SIG1_HIGH: return SELFTEST_SIG[15:8];
            SELFTEST_SIG2_LOW: return SELFTEST_SIG[23:16];
            SELFTEST_SIG2_HIGH: return SELFTEST_SIG[31:24];
            SILICON_IDENTITY: return IDENTITY_DEFAULT;
            default: return r[a] & srp_wmask(a);
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            rst_regs[i] = srp_reset_value(5'(i));
        end
    end

    // ------------------------------------------------------------------
    // Link decode
    // ------------------------------------------------------------------
    // Edges are found on CLOCK from the synchronised link clock; the link
    // clock itself clocks nothing, so one clock domain serves both ends
    assign sck_rise = q.sck_sync[1] & ~q.sck_sync[2];
    assign sck_fall = ~q.sck_sync[1] & q.sck_sync[2];
    assign cs_high = q.cs_sync[1];
    assign din = q.din_sync[1];
    assign low_first = q.regs[SERIAL_PORT_CONFIG][CFG_LOW_BIT_ORDER_BIT];
    assign three_wire = q.regs[SERIAL_PORT_CONFIG][CFG_WIRE_MODE_BIT];
    assign nxt_byte = low_first ? {din, q.shreg[7:1]} : {q.shreg[6:0], din};
    assign nxt_addr = low_first ? q.addr + 5'h01 : q.addr - 5'h01;

    always_comb begin
        d = q;
        d.sck_sync = {q.sck_sync[1:0], LINK.spi_clk};
        d.cs_sync = {q.cs_sync[0], LINK.chip_select_n};
        d.din_sync = {q.din_sync[0], LINK.dio};
        if (cs_high) begin
            // Held idle while deselected; low again starts an instruction
            d.in_instr = 1'b1;
            d.bitcnt = 3'h0;
            d.shreg = 8'h00;
            d.done = 1'b0;
            d.drive = 1'b0;
        end else begin
            if (sck_rise && !q.done) begin
                d.shreg = nxt_byte;
                d.bitcnt = q.bitcnt + 3'h1;
                if (q.bitcnt == 3'h7) begin
                    if (q.in_instr) begin
                        d.in_instr = 1'b0;
                        d.rd = nxt_byte[INSTR_RD_BIT];
                        d.left = nxt_byte[INSTR_CNT_MSB:INSTR_CNT_LSB];
                        d.addr = nxt_byte[INSTR_ADDR_MSB:0];
                        d.txbuf = read_reg(nxt_byte[INSTR_ADDR_MSB:0],
                                           q.regs);
                    end else begin
                        if (!q.rd) begin
                            // Config changes act on the very next bit
                            d.regs[q.addr] = (q.regs[q.addr]
                                & ~srp_wmask(q.addr))
                                | (nxt_byte & srp_wmask(q.addr));
                        end
                        d.addr = nxt_addr;
                        d.txbuf = read_reg(nxt_addr, d.regs);
                        if (q.left == 2'h0) begin
                            d.done = 1'b1;
                            d.drive = 1'b0;
                        end else begin
                            d.left = q.left - 2'h1;
                        end
                    end
                end
            end
            if (sck_fall && !q.in_instr && q.rd && !q.done) begin
                d.drive = 1'b1;
                d.dout = low_first ? q.txbuf[q.bitcnt]
                                   : q.txbuf[3'h7 - q.bitcnt];
            end
        end
        // Soft reset holds every register but the config at its default
        if (d.regs[SERIAL_PORT_CONFIG][CFG_SOFT_RESET_BIT]) begin
            for (int i = 1; i < 32; i++) begin
                d.regs[i] = rst_regs[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            q.sck_sync <= 3'h0;
            q.cs_sync <= 2'h3;
            q.din_sync <= 2'h0;
            q.in_instr <= 1'b1;
            q.rd <= 1'b0;
            q.done <= 1'b0;
            q.drive <= 1'b0;
            q.dout <= 1'b0;
            q.bitcnt <= 3'h0;
            q.left <= 2'h0;
            q.addr <= 5'h00;
            q.shreg <= 8'h00;
            q.txbuf <= 8'h00;
            q.regs <= '0;
            q.regs[CONV1_FULLSCALE_LOW] <= FULLSCALE_LOW_RST;
            q.regs[CONV2_FULLSCALE_LOW] <= FULLSCALE_LOW_RST;
            q.regs[CONV1_FULLSCALE_HIGH] <= FULLSCALE_HIGH_RST;
            q.regs[CONV2_FULLSCALE_HIGH] <= FULLSCALE_HIGH_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // The raw chip-select gates the enables so an abort floats the pins
    // at once, with no clock edge needed
    assign LINK.dev_dio_o = q.dout;
    assign LINK.dev_dio_oe = q.drive & three_wire
                             & ~LINK.chip_select_n;
    assign LINK.serial_out_pin_o = q.dout;
    assign LINK.serial_out_pin_oe = q.drive & ~three_wire
                                    & ~LINK.chip_select_n;
    assign REG_IMAGE = q.regs;
    assign SOFT_RESET = q.regs[SERIAL_PORT_CONFIG][CFG_SOFT_RESET_BIT];
endmodule

// ===== src/srp_host.sv
/*
 * Serial bus master for the register port, with a classic Wishbone slave
 * through which software loads an instruction and data and reads results.
 * Assumes the device answers read bits within six CLOCK cycles of a fall.
 */
`timescale 1ns/10ps
module srp_host (
    input wire logic CLOCK,
    input wire logic RST,
    srp_link_if.host LINK,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);
    import srp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        srp_host_state_t st;
        logic [3:0] div;
        logic [5:0] bi;
        logic [5:0] nbits;
        logic [9:0] ctrl;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic cs_n;
        logic sck;
        logic mo;
        logic ack;
        logic [31:0] rdat;
        logic [1:0] dio_sync;
        logic [1:0] so_sync;
    } srp_host_reg_t;

    srp_host_reg_t q;
    srp_host_reg_t d;
    logic tick;
    logic lsb;
    logic three;
    logic rd;
    logic req;
    logic din;
    logic [39:0] frame;

    // Bit k of the stream: byte k/8, bit order per byte from the mode
    function automatic logic stream_bit(input logic [5:0] k,
                                        input logic [39:0] f,
                                        input logic lf);
        logic [2:0] p;
        p = lf ? k[2:0] : 3'h7 - k[2:0];
        return f[{k[5:3], p}];
    endfunction

    assign lsb = q.ctrl[HOST_CTRL_LSB_FIRST_BIT];
    assign three = q.ctrl[HOST_CTRL_THREE_WIRE_BIT];
    assign rd = q.ctrl[INSTR_RD_BIT];
    assign frame = {q.txd, q.ctrl[7:0]};
    assign tick = (q.div == HOST_HALF_CYC - 4'h1);
    assign req = WB_CYC_I & WB_STB_I & ~q.ack;
    assign din = three ? q.dio_sync[1] : q.so_sync[1];

    // ------------------------------------------------------------------
    // Bus slave and frame sequencer
    // ------------------------------------------------------------------
    always_comb begin
        logic [5:0] k;
        k = q.bi - 6'(INSTR_BITS);
        d = q;
        d.dio_sync = {q.dio_sync[0], LINK.dio};
        d.so_sync = {q.so_sync[0], LINK.serial_out_pin};
        d.ack = req;
        if (q.st != SRP_H_IDLE) begin
            d.div = tick ? 4'h0 : q.div + 4'h1;
        end
        unique case (q.st)
            SRP_H_IDLE: begin
                d.cs_n = 1'b1;
                d.sck = 1'b0;
                if (req && WB_WE_I && WB_ADR_I == HOST_CTRL_ADR) begin
                    d.ctrl = WB_DAT_I[9:0];
                    d.nbits = {3'(WB_DAT_I[6:5]) + 3'h2, 3'h0};
                    d.bi = 6'h00;
                    d.div = 4'h0;
                    d.cs_n = 1'b0;
                    d.mo = stream_bit(6'h00, {q.txd, WB_DAT_I[7:0]},
                                      WB_DAT_I[HOST_CTRL_LSB_FIRST_BIT]);
                    d.st = SRP_H_LOW;
                end
            end
            SRP_H_LOW: begin
                if (tick) begin
                    d.sck = 1'b1;
                    if (rd && q.bi >= 6'(INSTR_BITS)) begin
                        d.rxd[{k[4:3], lsb ? k[2:0] : 3'h7 - k[2:0]}] = din;
                    end
                    d.st = SRP_H_HIGH;
                end
            end
            SRP_H_HIGH: begin
                if (tick) begin
                    d.sck = 1'b0;
                    d.bi = q.bi + 6'h01;
                    if (q.bi + 6'h01 == q.nbits) begin
                        d.st = SRP_H_END;
                    end else begin
                        d.mo = stream_bit(q.bi + 6'h01, frame, lsb);
                        d.st = SRP_H_LOW;
                    end
                end
            end
            SRP_H_END: begin
                // Chip-select stays low for the whole frame
                if (tick) begin
                    d.cs_n = 1'b1;
                    d.st = SRP_H_IDLE;
                end
            end
        endcase
        if (req && WB_WE_I && WB_ADR_I == HOST_TXDATA_ADR) begin
            for (int b = 0; b < 4; b++) begin
                if (WB_SEL_I[b]) begin
                    d.txd[b*8 +: 8] = WB_DAT_I[b*8 +: 8];
                end
            end
        end
        unique case (WB_ADR_I)
            HOST_CTRL_ADR: d.rdat = {22'h0, q.ctrl};
            HOST_TXDATA_ADR: d.rdat = q.txd;
            HOST_RXDATA_ADR: d.rdat = q.rxd;
            HOST_STATUS_ADR: d.rdat = {31'h0, q.st != SRP_H_IDLE};
            default: d.rdat = 32'h0;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            q <= '0;
            q.st <= SRP_H_IDLE;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // Link clock is CLOCK/16, well below the 40 MHz limit
    assign LINK.spi_clk = q.sck;
    assign LINK.chip_select_n = q.cs_n;
    assign LINK.host_dio_o = q.mo;
    assign LINK.host_dio_oe = ~q.cs_n
        & (~three | ~rd | q.bi < 6'(INSTR_BITS));
    assign WB_DAT_O = q.rdat;
    assign WB_ACK_O = q.ack;
endmodule

// ===== src/srp_link_if.sv
/*
 * Pins between the serial bus master and the register port device.
 * Resolves the shared data pins from the two ends' enables; an undriven
 * pin reads high, as with a pull-up.
 */
`timescale 1ns/10ps
interface srp_link_if;
    logic spi_clk;
    logic chip_select_n;
    logic host_dio_o;
    logic host_dio_oe;
    logic dev_dio_o;
    logic dev_dio_oe;
    logic serial_out_pin_o;
    logic serial_out_pin_oe;
    logic dio;
    logic serial_out_pin;

    assign dio = dev_dio_oe ? dev_dio_o : (host_dio_oe ? host_dio_o : 1'b1);
    assign serial_out_pin = serial_out_pin_oe ? serial_out_pin_o : 1'b1;

    modport dev (
        input spi_clk,
        input chip_select_n,
        input dio,
        output dev_dio_o,
        output dev_dio_oe,
        output serial_out_pin_o,
        output serial_out_pin_oe
    );
    modport host (
        output spi_clk,
        output chip_select_n,
        output host_dio_o,
        output host_dio_oe,
        input dio,
        input serial_out_pin
    );
endinterface

// ===== src/srp_pkg.sv
/*
 * Shared constants and types for the serial register port: the device's
 * register map, instruction layout, and the host controller's own map.
 * Assumes a single 25 MHz system clock on both ends.
 */
package srp_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_MAX_MHZ = 40;
    localparam int LINK_MIN_PERIOD_NS = 1000 / LINK_MAX_MHZ;
    localparam int LINK_MIN_HALF_CYC =
        (LINK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    // Slow enough that both ends' synchronisers settle within a half period
    localparam logic [3:0] HOST_HALF_CYC = 4'h8;

    // ------------------------------------------------------------------
    // Instruction byte
    // ------------------------------------------------------------------
    localparam int INSTR_RD_BIT = 7;
    localparam int INSTR_CNT_MSB = 6;
    localparam int INSTR_CNT_LSB = 5;
    localparam int INSTR_ADDR_MSB = 4;

    // ------------------------------------------------------------------
    // Device register map
    // ------------------------------------------------------------------
    localparam logic [4:0] SERIAL_PORT_CONFIG = 5'h00;
    localparam logic [4:0] INPUT_FORMAT_CONTROL = 5'h02;
    localparam logic [4:0] BLOCK_SHUTDOWN_CONTROL = 5'h03;
    localparam logic [4:0] INPUT_WINDOW_TIMING = 5'h04;
    localparam logic [4:0] SAMPLE_DELAY_ADJUST = 5'h05;
    localparam logic [4:0] INPUT_MARGIN_STATUS = 5'h06;
    localparam logic [4:0] OUTPUT_MODE_SELECT = 5'h0a;
    localparam logic [4:0] CONV1_FULLSCALE_LOW = 5'h0b;
    localparam logic [4:0] CONV1_FULLSCALE_HIGH = 5'h0c;
    localparam logic [4:0] AUX1_CURRENT_LOW = 5'h0d;
    localparam logic [4:0] AUX1_CURRENT_HIGH = 5'h0e;
    localparam logic [4:0] CONV2_FULLSCALE_LOW = 5'h0f;
    localparam logic [4:0] CONV2_FULLSCALE_HIGH = 5'h10;
    localparam logic [4:0] AUX2_CURRENT_LOW = 5'h11;
    localparam logic [4:0] AUX2_CURRENT_HIGH = 5'h12;
    localparam logic [4:0] SELFTEST_CONTROL = 5'h1a;
    localparam logic [4:0] SELFTEST_SIG1_LOW = 5'h1b;
    localparam logic [4:0] SELFTEST_SIG1_HIGH = 5'h1c;
    localparam logic [4:0] SELFTEST_SIG2_LOW = 5'h1d;
    localparam logic [4:0] SELFTEST_SIG2_HIGH = 5'h1e;
    localparam logic [4:0] SILICON_IDENTITY = 5'h1f;

    localparam int CFG_WIRE_MODE_BIT = 7;
    localparam int CFG_LOW_BIT_ORDER_BIT = 6;
    localparam int CFG_SOFT_RESET_BIT = 5;
    localparam logic [7:0] FULLSCALE_LOW_RST = 8'hf9;
    localparam logic [7:0] FULLSCALE_HIGH_RST = 8'h01;
    localparam logic [7:0] REG_RST = 8'h00;
    // Arbitrary identity value, no meaning beyond this model
    localparam logic [7:0] IDENTITY_DEFAULT = 8'h5a;

    function automatic logic [7:0] srp_wmask(input logic [4:0] a);
        unique case (a)
            SERIAL_PORT_CONFIG, SELFTEST_CONTROL: return 8'he0;
            INPUT_FORMAT_CONTROL: return 8'h90;
            BLOCK_SHUTDOWN_CONTROL, INPUT_WINDOW_TIMING: return 8'hff;
            CONV1_FULLSCALE_LOW, AUX1_CURRENT_LOW: return 8'hff;
            CONV2_FULLSCALE_LOW, AUX2_CURRENT_LOW: return 8'hff;
            SAMPLE_DELAY_ADJUST: return 8'h1f;
            OUTPUT_MODE_SELECT: return 8'h0f;
            CONV1_FULLSCALE_HIGH, CONV2_FULLSCALE_HIGH: return 8'h03;
            AUX1_CURRENT_HIGH, AUX2_CURRENT_HIGH: return 8'hc3;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] srp_reset_value(input logic [4:0] a);
        unique case (a)
            CONV1_FULLSCALE_LOW, CONV2_FULLSCALE_LOW: return FULLSCALE_LOW_RST;
            CONV1_FULLSCALE_HIGH, CONV2_FULLSCALE_HIGH:
                return FULLSCALE_HIGH_RST;
            default: return REG_RST;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Host controller map (byte addresses on its bus)
    // ------------------------------------------------------------------
    localparam logic [3:0] HOST_CTRL_ADR = 4'h0;
    localparam logic [3:0] HOST_TXDATA_ADR = 4'h4;
    localparam logic [3:0] HOST_RXDATA_ADR = 4'h8;
    localparam logic [3:0] HOST_STATUS_ADR = 4'hc;
    localparam int HOST_CTRL_LSB_FIRST_BIT = 8;
    localparam int HOST_CTRL_THREE_WIRE_BIT = 9;
    localparam int INSTR_BITS = 8;

    typedef enum logic [1:0] {
        SRP_H_IDLE = 2'b00,
        SRP_H_LOW = 2'b01,
        SRP_H_HIGH = 2'b11,
        SRP_H_END = 2'b10
    } srp_host_state_t;
endpackage
